// ===== hdl/tpc_timer_pins.sv
`timescale 1ns/1ps
module tpc_timer_pins (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [tpc_pkg::ADDR_W-1:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [tpc_pkg::ADDR_W-1:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	input wire logic external_count_clock_in,
	input wire logic fixed_clock_tick,
	input wire logic [tpc_pkg::NCH-1:0] gpio_data_out,
	input wire logic [tpc_pkg::NCH-1:0] gpio_dir_out,
	input wire logic [tpc_pkg::NCH-1:0] channel_pin_i,
	output logic [tpc_pkg::NCH-1:0] channel_pin_o,
	output logic [tpc_pkg::NCH-1:0] channel_pin_oe
);
	localparam int NCH = tpc_pkg::NCH;
	localparam int CW = tpc_pkg::CNT_W;

	logic [tpc_pkg::PS_W-1:0] prescale;
	logic [1:0] count_clock_select;
	logic center_align_select;
	logic ext_on_pin;
	logic [tpc_pkg::SEL_W-1:0] ext_pin_sel;
	logic [CW-1:0] counter_value;
	logic [CW-1:0] modulo_value;
	logic count_down;
	logic [tpc_pkg::PRE_W-1:0] pre_cnt;
	logic count_step;
	logic [1:0] edge_level_select [NCH];
	logic [1:0] channel_mode_select [NCH];
	logic [CW-1:0] ch_val [NCH];
	logic [NCH-1:0] ch_flag;
	logic [NCH-1:0] pin_lvl;
	logic [NCH-1:0] pin_rise;
	logic [NCH-1:0] pin_fall;
	logic [NCH-1:0] own;
	logic [NCH-1:0] is_cap;
	logic [NCH-1:0] match;
	logic [NCH-1:0] out_q;
	logic ext_rise;
	logic aw_held;
	logic w_held;
	logic [tpc_pkg::ADDR_W-1:0] aw_addr;
	logic [31:0] w_data;
	logic [3:0] w_strb;
	logic wr_fire;
	logic cnt_wr;
	logic src_tick;
	logic count_tick;
	logic [7:0] ps_onehot;
	logic [tpc_pkg::PRE_W-1:0] ps_mask;
	logic [tpc_pkg::SEL_W-1:0] w_idx;
	logic [31:0] next_rdata;
	logic next_rmapped;

	function automatic logic [CW-1:0] merge16(input logic [CW-1:0] old, input logic [31:0] d,
			input logic [3:0] s);
		merge16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
	endfunction : merge16

	function automatic logic mapped(input logic [tpc_pkg::ADDR_W-1:0] a);
		mapped = a[tpc_pkg::CH_AREA_BIT] || (a == tpc_pkg::OFF_CTRL)
			|| (a == tpc_pkg::OFF_COUNT) || (a == tpc_pkg::OFF_MOD);
	endfunction : mapped

	////////////////////////////////////////////////////////////////////////////
	// AXI4-Lite write path: address and data held independently
	assign awready = !aw_held && !bvalid;
	assign wready = !w_held && !bvalid;
	assign wr_fire = aw_held && w_held && !bvalid;
	assign w_idx = aw_addr[tpc_pkg::CH_IDX_LSB +: tpc_pkg::SEL_W];
	assign cnt_wr = wr_fire && (aw_addr == tpc_pkg::OFF_COUNT);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
			aw_addr <= '0;
			w_data <= '0;
			w_strb <= '0;
			bvalid <= 1'b0;
			bresp <= tpc_pkg::RESP_OKAY;
		end else begin
			if (awvalid && awready) begin
				aw_held <= 1'b1;
				aw_addr <= awaddr;
			end
			if (wvalid && wready) begin
				w_held <= 1'b1;
				w_data <= wdata;
				w_strb <= wstrb;
			end
			if (wr_fire) begin
				aw_held <= 1'b0;
				w_held <= 1'b0;
				bvalid <= 1'b1;
				bresp <= mapped(aw_addr) ? tpc_pkg::RESP_OKAY : tpc_pkg::RESP_SLVERR;
			end else if (bready) begin
				bvalid <= 1'b0;
			end
		end
	end

	// Global control; reset leaves the clock off so no channel owns a pin
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			prescale <= '0;
			count_clock_select <= tpc_pkg::CLKS_OFF;
			center_align_select <= 1'b0;
			ext_on_pin <= 1'b0;
			ext_pin_sel <= '0;
			modulo_value <= tpc_pkg::CNT_ZERO;
		end else if (wr_fire) begin
			if (aw_addr == tpc_pkg::OFF_CTRL && w_strb[0]) begin
				prescale <= w_data[tpc_pkg::CTRL_PS_LSB +: tpc_pkg::PS_W];
				count_clock_select <= w_data[tpc_pkg::CTRL_CLKS_LSB +: 2];
				center_align_select <= w_data[tpc_pkg::CTRL_CPWM_BIT];
				ext_on_pin <= w_data[tpc_pkg::CTRL_EXTPIN_BIT];
			end
			if (aw_addr == tpc_pkg::OFF_CTRL && w_strb[1]) begin
				ext_pin_sel <= w_data[tpc_pkg::CTRL_EXTSEL_LSB +: tpc_pkg::SEL_W];
			end
			if (aw_addr == tpc_pkg::OFF_MOD) begin
				modulo_value <= merge16(modulo_value, w_data, w_strb);
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// AXI4-Lite read path: one read at a time, data registered
	assign arready = !rvalid;

	always_comb begin
		next_rdata = '0;
		next_rmapped = mapped(araddr);
		if (araddr[tpc_pkg::CH_AREA_BIT]) begin
			if (araddr[tpc_pkg::CH_VAL_BIT]) begin
				next_rdata[CW-1:0] = ch_val[araddr[tpc_pkg::CH_IDX_LSB +: tpc_pkg::SEL_W]];
			end else begin
				next_rdata[tpc_pkg::CH_ELS_LSB +: 2] =
					edge_level_select[araddr[tpc_pkg::CH_IDX_LSB +: tpc_pkg::SEL_W]];
				next_rdata[tpc_pkg::CH_MS_LSB +: 2] =
					channel_mode_select[araddr[tpc_pkg::CH_IDX_LSB +: tpc_pkg::SEL_W]];
				next_rdata[tpc_pkg::CH_FLAG_BIT] =
					ch_flag[araddr[tpc_pkg::CH_IDX_LSB +: tpc_pkg::SEL_W]];
			end
		end else if (araddr == tpc_pkg::OFF_CTRL) begin
			next_rdata[tpc_pkg::CTRL_PS_LSB +: tpc_pkg::PS_W] = prescale;
			next_rdata[tpc_pkg::CTRL_CLKS_LSB +: 2] = count_clock_select;
			next_rdata[tpc_pkg::CTRL_CPWM_BIT] = center_align_select;
			next_rdata[tpc_pkg::CTRL_EXTPIN_BIT] = ext_on_pin;
			next_rdata[tpc_pkg::CTRL_EXTSEL_LSB +: tpc_pkg::SEL_W] = ext_pin_sel;
		end else if (araddr == tpc_pkg::OFF_COUNT) begin
			next_rdata[CW-1:0] = counter_value;
		end else if (araddr == tpc_pkg::OFF_MOD) begin
			next_rdata[CW-1:0] = modulo_value;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid <= 1'b0;
			rdata <= '0;
			rresp <= tpc_pkg::RESP_OKAY;
		end else if (arvalid && arready) begin
			rvalid <= 1'b1;
			rdata <= next_rdata;
			rresp <= next_rmapped ? tpc_pkg::RESP_OKAY : tpc_pkg::RESP_SLVERR;
		end else if (rready) begin
			rvalid <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Clock source and prescaler
	tpc_sync u_ext_sync (
		.aclk(aclk),
		.aresetn(aresetn),
		.async_in(external_count_clock_in),
		.level(),
		.rise(ext_rise),
		.fall()
	);

	always_comb begin
		case (count_clock_select)
			tpc_pkg::CLKS_BUS: src_tick = 1'b1;
			tpc_pkg::CLKS_FIXED: src_tick = fixed_clock_tick;
			tpc_pkg::CLKS_EXT: src_tick = ext_on_pin ? pin_rise[ext_pin_sel] : ext_rise;
			default: src_tick = 1'b0;
		endcase
	end

	assign ps_onehot = 8'h01 << prescale;
	assign ps_mask = tpc_pkg::PRE_W'(ps_onehot - 8'h01);
	assign count_tick = src_tick && ((pre_cnt & ps_mask) == ps_mask);

	always_ff @(posedge aclk) begin
		if (!aresetn || count_clock_select == tpc_pkg::CLKS_OFF) begin
			pre_cnt <= '0;
		end else if (src_tick) begin
			pre_cnt <= pre_cnt + 7'h01;
		end
	end

	// Counter: up with modulo wrap, or up/down in center-aligned mode
	always_ff @(posedge aclk) begin
		if (!aresetn || cnt_wr) begin
			counter_value <= tpc_pkg::CNT_ZERO;
			count_down <= 1'b0;
		end else if (count_tick) begin
			if (center_align_select) begin
				if (!count_down) begin
					if (counter_value >= modulo_value) begin
						count_down <= (modulo_value != tpc_pkg::CNT_ZERO);
						counter_value <= (modulo_value == tpc_pkg::CNT_ZERO) ?
							tpc_pkg::CNT_ZERO : counter_value - tpc_pkg::CNT_ONE;
					end else begin
						counter_value <= counter_value + tpc_pkg::CNT_ONE;
					end
				end else if (counter_value == tpc_pkg::CNT_ZERO) begin
					count_down <= 1'b0;
					counter_value <= counter_value + tpc_pkg::CNT_ONE;
				end else begin
					counter_value <= counter_value - tpc_pkg::CNT_ONE;
				end
			end else begin
				count_down <= 1'b0;
				if (modulo_value != tpc_pkg::CNT_ZERO && counter_value == modulo_value) begin
					counter_value <= tpc_pkg::CNT_ZERO;
				end else begin
					counter_value <= counter_value + tpc_pkg::CNT_ONE;
				end
			end
		end
	end

	// Compares look at the count one cycle after it moved
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			count_step <= 1'b0;
		end else begin
			count_step <= count_tick;
		end
	end

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	sequence s_stopped;
		count_clock_select == tpc_pkg::CLKS_OFF && !cnt_wr;
	endsequence
	sequence s_at_top;
		center_align_select && count_tick && !count_down && !cnt_wr
			&& modulo_value != tpc_pkg::CNT_ZERO && counter_value == modulo_value;
	endsequence

	AST_STOPPED_HOLDS: assert property (s_stopped |=> $stable(counter_value))
		else $error("counter moved with no clock selected");
	AST_CENTER_TURN: assert property (s_at_top |=> count_down
		&& counter_value == $past(modulo_value) - tpc_pkg::CNT_ONE)
		else $error("center count did not turn down at modulo");
	AST_EDGE_WRAP: assert property (!center_align_select && count_tick && !cnt_wr
		&& modulo_value != tpc_pkg::CNT_ZERO && counter_value == modulo_value
		|=> counter_value == tpc_pkg::CNT_ZERO)
		else $error("edge count did not wrap after modulo");

	////////////////////////////////////////////////////////////////////////////
	// Per-channel pin logic
	for (genvar i = 0; i < NCH; i++) begin : g_ch
		logic ch_sel;
		logic cap_edge;

		tpc_sync u_pin_sync (
			.aclk(aclk),
			.aresetn(aresetn),
			.async_in(channel_pin_i[i]),
			.level(pin_lvl[i]),
			.rise(pin_rise[i]),
			.fall(pin_fall[i])
		);

		assign ch_sel = wr_fire && aw_addr[tpc_pkg::CH_AREA_BIT] && (w_idx == i);
		// A pin feeding the count clock is never owned and stays under gpio control; compare still times it
		assign own[i] = edge_level_select[i] != tpc_pkg::ELS_NONE
			&& count_clock_select != tpc_pkg::CLKS_OFF
			&& !(ext_on_pin && count_clock_select == tpc_pkg::CLKS_EXT && ext_pin_sel == i);
		assign is_cap[i] = own[i] && !center_align_select
			&& channel_mode_select[i] == tpc_pkg::MS_CAPTURE;
		assign cap_edge = (edge_level_select[i][0] && pin_rise[i])
			|| (edge_level_select[i][1] && pin_fall[i]);
		assign match[i] = count_step && counter_value == ch_val[i];

		always_ff @(posedge aclk) begin
			if (!aresetn) begin
				edge_level_select[i] <= tpc_pkg::ELS_NONE;
				channel_mode_select[i] <= tpc_pkg::MS_CAPTURE;
			end else if (ch_sel && !aw_addr[tpc_pkg::CH_VAL_BIT] && w_strb[0]) begin
				edge_level_select[i] <= w_data[tpc_pkg::CH_ELS_LSB +: 2];
				channel_mode_select[i] <= w_data[tpc_pkg::CH_MS_LSB +: 2];
			end
		end

		// Capture beats a bus write landing in the same cycle
		always_ff @(posedge aclk) begin
			if (!aresetn) begin
				ch_val[i] <= tpc_pkg::CNT_ZERO;
			end else if (is_cap[i] && cap_edge) begin
				ch_val[i] <= counter_value;
			end else if (ch_sel && aw_addr[tpc_pkg::CH_VAL_BIT]) begin
				ch_val[i] <= merge16(ch_val[i], w_data, w_strb);
			end
		end

		// Event flag: a new event wins over a write-one clear
		always_ff @(posedge aclk) begin
			if (!aresetn) begin
				ch_flag[i] <= 1'b0;
			end else if ((is_cap[i] && cap_edge) || (!is_cap[i] && match[i])) begin
				ch_flag[i] <= 1'b1;
			end else if (ch_sel && !aw_addr[tpc_pkg::CH_VAL_BIT] && w_strb[0]
					&& w_data[tpc_pkg::CH_FLAG_BIT]) begin
				ch_flag[i] <= 1'b0;
			end
		end

		// Unowned pins track their level so toggle starts from it
		always_ff @(posedge aclk) begin
			if (!aresetn) begin
				out_q[i] <= 1'b0;
			end else if (!own[i]) begin
				out_q[i] <= pin_lvl[i];
			end else if (center_align_select) begin
				if (match[i]) begin
					out_q[i] <= count_down ? !edge_level_select[i][0]
						: edge_level_select[i][0];
				end
			end else if (channel_mode_select[i][1]) begin
				if (match[i]) begin
					out_q[i] <= edge_level_select[i][0];
				end else if (count_step && counter_value == tpc_pkg::CNT_ZERO) begin
					out_q[i] <= !edge_level_select[i][0];
				end
			end else if (channel_mode_select[i] == tpc_pkg::MS_COMPARE && match[i]) begin
				case (edge_level_select[i])
					tpc_pkg::ELS_TOGGLE: out_q[i] <= !out_q[i];
					tpc_pkg::ELS_CLEAR: out_q[i] <= 1'b0;
					tpc_pkg::ELS_SET: out_q[i] <= 1'b1;
					default: out_q[i] <= out_q[i];
				endcase
			end
		end

		always_ff @(posedge aclk) begin
			if (!aresetn) begin
				channel_pin_o[i] <= 1'b0;
				channel_pin_oe[i] <= 1'b0;
			end else if (own[i]) begin
				channel_pin_o[i] <= out_q[i];
				channel_pin_oe[i] <= !is_cap[i];
			end else begin
				channel_pin_o[i] <= gpio_data_out[i];
				channel_pin_oe[i] <= gpio_dir_out[i];
			end
		end

		sequence s_toggle_hit;
			own[i] && !center_align_select && channel_mode_select[i] == tpc_pkg::MS_COMPARE
				&& edge_level_select[i] == tpc_pkg::ELS_TOGGLE && match[i];
		endsequence

		AST_RELEASE: assert property (!own[i] |=> channel_pin_oe[i] == $past(gpio_dir_out[i])
			&& channel_pin_o[i] == $past(gpio_data_out[i]))
			else $error("released pin not under port control");
		AST_CAPTURE_INPUT: assert property (is_cap[i] |=> !channel_pin_oe[i])
			else $error("capture pin is driven");
		AST_OUTPUT_DRIVE: assert property (own[i] && (center_align_select
			|| channel_mode_select[i] != tpc_pkg::MS_CAPTURE) |=> channel_pin_oe[i])
			else $error("output channel pin not driven");
		AST_TOGGLE: assert property (s_toggle_hit |=> out_q[i] != $past(out_q[i]))
			else $error("toggle match did not invert pin");
		AST_TOGGLE_HOLD: assert property (own[i] && !center_align_select
			&& channel_mode_select[i] == tpc_pkg::MS_COMPARE && !match[i]
			&& $past(own[i]) |=> $stable(out_q[i]))
			else $error("compare pin moved without a match");
		AST_CAPTURE_VALUE: assert property (is_cap[i] && cap_edge
			|=> ch_val[i] == $past(counter_value))
			else $error("capture did not store the count");
		AST_EPWM_START: assert property (own[i] && !center_align_select
			&& channel_mode_select[i][1] && edge_level_select[i] == tpc_pkg::ELS_CLEAR
			&& count_step && counter_value == tpc_pkg::CNT_ZERO && !match[i]
			##1 own[i] |-> out_q[i] ##1 channel_pin_o[i])
			else $error("edge PWM did not rise at period start");
	end
endmodule : tpc_timer_pins

// ===== hdl/tpc_pkg.sv
package tpc_pkg;
	localparam int NCH = 8;
	localparam int CNT_W = 16;
	localparam int ADDR_W = 7;
	localparam int PS_W = 3;
	localparam int PRE_W = 7;
	localparam int SEL_W = 3;

	// Register byte offsets
	localparam logic [ADDR_W-1:0] OFF_CTRL = 7'h00;
	localparam logic [ADDR_W-1:0] OFF_COUNT = 7'h04;
	localparam logic [ADDR_W-1:0] OFF_MOD = 7'h08;
	// Channel block: control at 0x40 + 8*n, value at 0x44 + 8*n
	localparam int CH_AREA_BIT = 6;
	localparam int CH_IDX_LSB = 3;
	localparam int CH_VAL_BIT = 2;

	// Control register fields
	localparam int CTRL_PS_LSB = 0;
	localparam int CTRL_CLKS_LSB = 3;
	localparam int CTRL_CPWM_BIT = 5;
	localparam int CTRL_EXTPIN_BIT = 6;
	localparam int CTRL_EXTSEL_LSB = 8;

	// Channel control fields
	localparam int CH_ELS_LSB = 0;
	localparam int CH_MS_LSB = 2;
	localparam int CH_FLAG_BIT = 7;

	localparam logic [1:0] CLKS_OFF = 2'h0;
	localparam logic [1:0] CLKS_BUS = 2'h1;
	localparam logic [1:0] CLKS_FIXED = 2'h2;
	localparam logic [1:0] CLKS_EXT = 2'h3;

	localparam logic [1:0] ELS_NONE = 2'h0;
	localparam logic [1:0] ELS_TOGGLE = 2'h1;
	localparam logic [1:0] ELS_CLEAR = 2'h2;
	localparam logic [1:0] ELS_SET = 2'h3;

	localparam logic [1:0] MS_CAPTURE = 2'h0;
	localparam logic [1:0] MS_COMPARE = 2'h1;

	localparam logic [CNT_W-1:0] CNT_ZERO = 16'h0000;
	localparam logic [CNT_W-1:0] CNT_ONE = 16'h0001;

	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : tpc_pkg

// ===== hdl/tpc_sync.sv
`timescale 1ns/1ps
module tpc_sync (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic async_in,
	output logic level,
	output logic rise,
	output logic fall
);
	logic s1;
	logic s2;
	logic s3;

	// Stages run through reset so the detector starts from the pin's real level,
	// otherwise a pulled-up pin would show a false rising edge after reset
	always_ff @(posedge aclk) begin
		s1 <= async_in;
		s2 <= s1;
		s3 <= s2;
	end

	// A change counts only once the second and third stages agree
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			level <= s3;
			rise <= 1'b0;
			fall <= 1'b0;
		end else begin
			rise <= (s2 == s3) && s3 && !level;
			fall <= (s2 == s3) && !s3 && level;
			if (s2 == s3) begin
				level <= s3;
			end
		end
	end
endmodule : tpc_sync

// ===== tb/tpc_pin_env.sv
`timescale 1ns/1ps
module tpc_pin_env (
	input wire logic aclk,
	input wire logic [7:0] pin_o,
	input wire logic [7:0] pin_oe,
	input wire logic [7:0] ext_en,
	input wire logic [7:0] ext_val,
	output logic [7:0] pin_i,
	output logic ext_clk
);
	// Index 8 means the dedicated clock pin; the source stands still at 0 between bursts
	logic clk_lvl = 1'b0;
	int clk_pin = -1;
	////////////////////////////////////////////////////////////////////////////////
	// Undriven pins float up through the pull-up
	always_comb begin
		for (int k = 0; k < 8; k++) begin
			if (pin_oe[k])
				pin_i[k] = pin_o[k];
			else if (clk_pin == k)
				pin_i[k] = clk_lvl;
			else if (ext_en[k])
				pin_i[k] = ext_val[k];
			else
				pin_i[k] = 1'b1;
		end
	end
	assign ext_clk = (clk_pin == 8) & clk_lvl;
	////////////////////////////////////////////////////////////////////////////////
	// One eighth of the bus rate leaves margin below the quarter-rate ceiling
	task burst(input int n, input int pin);
		clk_pin = pin;
		repeat (n) begin
			@(posedge aclk);
			clk_lvl <= 1'b1;
			repeat (4) @(posedge aclk);
			clk_lvl <= 1'b0;
			repeat (3) @(posedge aclk);
		end
	endtask : burst
endmodule : tpc_pin_env

// ===== tb/tb.sv
`timescale 1ns/1ps
module tb;
	logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
	logic awready, wready, bvalid, arready, rvalid, ext_clk, fix_tick;
	logic [tpc_pkg::ADDR_W-1:0] awaddr, araddr;
	logic [31:0] wdata, rdata, rd;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp, rsp;
	logic [7:0] gdat, gdir, pin_i, pin_o, pin_oe, ext_en, ext_val;
	int error_cnt = 0, total_checks = 0, cyc = 0, h, t0;

	tpc_timer_pins tpc_timer_pins_inst (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
		.awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
		.wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
		.arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
		.rready(rready), .external_count_clock_in(ext_clk), .fixed_clock_tick(fix_tick),
		.gpio_data_out(gdat), .gpio_dir_out(gdir), .channel_pin_i(pin_i),
		.channel_pin_o(pin_o), .channel_pin_oe(pin_oe));
	tpc_pin_env tpc_pin_env_inst (.aclk(aclk), .pin_o(pin_o), .pin_oe(pin_oe),
		.ext_en(ext_en), .ext_val(ext_val), .pin_i(pin_i), .ext_clk(ext_clk));
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		aclk = 1'b0;
		forever #4 aclk = ~aclk;
	end
	// Fixed clock ticks every fourth cycle; the cycle ceiling cuts a hang short
	always @(posedge aclk) begin
		cyc <= cyc + 1;
		fix_tick <= ((cyc % 4) == 3);
		if (cyc == 40000) begin
			error_cnt++;
			$display("[ERR] %0t timeout", $time);
			print_verdict();
		end
	end
	////////////////////////////////////////////////////////////////////////////////
	task print_verdict();
		$display("checks %0d mismatches %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : print_verdict
	task chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
		total_checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("[ERR] %0t %s: got %h exp %h", $time, what, seen, exp);
		end
	endtask : chk
	task wr(input logic [tpc_pkg::ADDR_W-1:0] a, input logic [31:0] d);
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while (!bvalid);
		bready <= 1'b0;
		rsp = bresp;
	endtask : wr
	task rdt(input logic [tpc_pkg::ADDR_W-1:0] a, output logic [31:0] d);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (arready) arvalid <= 1'b0;
		end while (!rvalid);
		rready <= 1'b0;
		rsp = rresp;
		d = rdata;
	endtask : rdt
	task wp(input int ch, input logic v);
		while (pin_o[ch] !== v) @(posedge aclk);
	endtask : wp
	task hi_cnt(input int ch, input int n);
		h = 0;
		repeat (n) begin
			@(posedge aclk);
			if (pin_o[ch] === 1'b1) h++;
		end
	endtask : hi_cnt
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		aresetn = 1'b0;
		{awvalid, wvalid, bready, arvalid, rready} = '0;
		awaddr = '0;
		araddr = '0;
		wdata = '0;
		wstrb = 4'hf;
		gdat = 8'h35;
		gdir = 8'h0a;
		ext_en = 8'h02;
		ext_val = 8'hff;
		repeat (10) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (3) @(posedge aclk);
		chk(pin_oe, gdir, "reset oe");
		chk(pin_o, gdat, "reset data");
		$display("test reset done");
		wr(7'h20, 32'h0000_1234);
		chk(rsp, tpc_pkg::RESP_SLVERR, "unmapped wr");
		rdt(7'h20, rd);
		chk(rsp, tpc_pkg::RESP_SLVERR, "unmapped rresp");
		chk(rd, 32'h0000_0000, "unmapped rd");
		wr(tpc_pkg::OFF_MOD, 32'h0000_00ff);
		chk(rsp, tpc_pkg::RESP_OKAY, "mod wr");
		rdt(tpc_pkg::OFF_MOD, rd);
		chk(rsp, tpc_pkg::RESP_OKAY, "mod rresp");
		chk(rd, 32'h0000_00ff, "mod rd");
		$display("test bus done");
		// Compare on channel 0: clear, set, then toggle from the held level;
		// the pin idles high through its pull-up, so clear comes first to be seen
		wr(7'h44, 32'h0000_0080);
		wr(7'h40, 32'h0000_0006);
		wr(tpc_pkg::OFF_CTRL, 32'h0000_0008);
		wp(0, 1'b0);
		chk(pin_oe[0], 1'b1, "compare oe");
		wr(7'h40, 32'h0000_0007);
		wp(0, 1'b1);
		wr(7'h40, 32'h0000_0005);
		repeat (4) @(posedge aclk);
		chk(pin_o[0], 1'b1, "toggle holds");
		wp(0, 1'b0);
		t0 = cyc;
		wp(0, 1'b1);
		chk(cyc - t0, 256, "toggle interval");
		$display("test compare done");
		// Capture on channel 1 overrides a gpio output direction
		wr(7'h48, 32'h0000_0083);
		repeat (4) @(posedge aclk);
		chk(pin_oe[1], 1'b0, "capture oe");
		// Releasing the gpio drive lets the pin rise; drop that event first
		repeat (8) @(posedge aclk);
		wr(7'h48, 32'h0000_0083);
		rdt(7'h48, rd);
		chk(rd[7], 1'b0, "flag cleared");
		ext_val[1] <= 1'b0;
		repeat (4) @(posedge aclk);
		ext_val[1] <= 1'b1;
		repeat (8) @(posedge aclk);
		rdt(7'h48, rd);
		chk(rd[7], 1'b1, "capture flag");
		$display("test capture done");
		wr(7'h54, 32'h0000_0040);
		// A new polarity only shows after the next event, so let a period pass
		wr(7'h50, 32'h0000_000a);
		repeat (260) @(posedge aclk);
		hi_cnt(2, 256);
		chk(h, 64, "epwm high");
		wr(7'h50, 32'h0000_0009);
		repeat (260) @(posedge aclk);
		hi_cnt(2, 256);
		chk(h, 192, "epwm low");
		wr(7'h50, 32'h0000_0008);
		repeat (4) @(posedge aclk);
		chk(pin_oe[2], gdir[2], "released");
		$display("test epwm done");
		// Period is twice the modulo, so a 256-cycle window holds one whole period
		wr(tpc_pkg::OFF_MOD, 32'h0000_0080);
		wr(7'h54, 32'h0000_0020);
		wr(7'h50, 32'h0000_000a);
		wr(tpc_pkg::OFF_CTRL, 32'h0000_0028);
		wr(tpc_pkg::OFF_COUNT, 32'h0000_0000);
		repeat (300) @(posedge aclk);
		hi_cnt(2, 256);
		chk(h, 64, "cpwm high");
		chk(pin_oe[1:0], 2'b11, "cpwm oe");
		wr(7'h50, 32'h0000_0009);
		repeat (260) @(posedge aclk);
		hi_cnt(2, 256);
		chk(h, 192, "cpwm low");
		rdt(tpc_pkg::OFF_COUNT, rd);
		chk(rd <= 32'h0000_0080, 1'b1, "cpwm range");
		$display("test cpwm done");
		wr(tpc_pkg::OFF_CTRL, 32'h0000_0000);
		wr(tpc_pkg::OFF_COUNT, 32'h0000_0000);
		repeat (20) @(posedge aclk);
		chk({pin_oe, pin_o}, {gdir, gdat}, "clock off pins");
		rdt(tpc_pkg::OFF_COUNT, rd);
		chk(rd, 32'h0000_0000, "stopped");
		for (int m = 0; m < 2; m++) begin
			// Fixed tick and bus clock divided by four both give one count in four cycles
			wr(tpc_pkg::OFF_CTRL, m ? 32'h0000_000a : 32'h0000_0010);
			wr(tpc_pkg::OFF_COUNT, 32'h0000_0000);
			repeat (100) @(posedge aclk);
			rdt(tpc_pkg::OFF_COUNT, rd);
			chk(rd >= 24 && rd <= 28, 1'b1, "fixed or prescaled rate");
		end
		for (int p = 0; p < 2; p++) begin
			wr(tpc_pkg::OFF_CTRL, p ? 32'h0000_0458 : 32'h0000_0018);
			wr(tpc_pkg::OFF_COUNT, 32'h0000_0000);
			wr(7'h64, 32'h0000_0005);
			wr(7'h60, 32'h0000_0084);
			tpc_pin_env_inst.burst(20, p ? 4 : 8);
			repeat (10) @(posedge aclk);
			rdt(tpc_pkg::OFF_COUNT, rd);
			chk(rd, 32'h0000_0014, "external count");
		end
		rdt(7'h60, rd);
		chk(rd[7], 1'b1, "pinless compare flag");
		chk(pin_oe[4], 1'b0, "clock pin released");
		$display("test clocks done");
		print_verdict();
	end
endmodule : tb
